// ---- core/hpi_pkg.sv ----
/*
 * shared constants for the host port interrupt logic: request bit layout,
 * register indices, bus width and byte order settings.
 * assumes both ends and the interface are compiled after this package.
 */
package hpi_pkg;
    localparam int          NUM_REQ           = 9;
    localparam int          REQ_LSB           = 1;
    // register indices selected by the address port
    localparam logic [7:0]  REG_STATUS        = 8'h00;
    localparam logic [7:0]  REG_INT_ENABLE    = 8'h05;
    localparam logic [7:0]  REG_INT_ACK       = 8'h06;
    localparam logic [7:0]  REG_BUS_WIDTH     = 8'h07;
    localparam logic [7:0]  REG_BYTE_ORDER    = 8'h08;
    localparam logic [7:0]  REG_SELECT        = 8'h09;
    // status bit positions
    localparam int          STAT_SUMMARY      = 0;
    localparam int          STAT_IDLE         = 10;
    localparam int          STAT_FIFO_PIN     = 14;
    localparam int          STAT_BLOCK_PIN    = 15;
    localparam logic [15:0] ENABLE_RESET      = 16'h0000;
    localparam logic        BYTE_ORDER_RESET  = 1'b0;
    localparam logic        HIGH_FIRST        = 1'b0;
    localparam logic        WIDE_BUS_RESET    = 1'b1;
    typedef enum logic [1:0] {HPI_OP_WRITE, HPI_OP_READ, HPI_OP_ADDR} hpi_op_t;
endpackage

// ---- core/hpi_if.sv ----
/*
 * parallel host bus between host end and device end, plus interrupt and request pins.
 * assumes one sys_clk for both ends; data is split per direction.
 */
`timescale 1ns/1ps
interface hpi_if;
    logic        cs;
    logic        wr;
    logic        rd;
    logic        addr_sel;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic        rvalid;
    logic        host_int;
    logic        instr_fifo_request_pin;
    logic        block_transfer_request_pin;
    modport device (input cs, wr, rd, addr_sel, wdata,
                    output rdata, rvalid, host_int, instr_fifo_request_pin, block_transfer_request_pin);
    modport host   (output cs, wr, rd, addr_sel, wdata,
                    input rdata, rvalid, host_int, instr_fifo_request_pin, block_transfer_request_pin);
endinterface

// ---- core/hpi_device.sv ----
/*
 * device end: interrupt request latches, enable and acknowledge, status,
 * 8/16-bit host port with byte order, cascade sync pins.
 * assumes the host holds each request one cycle and keeps byte pairs adjacent.
 */
`timescale 1ns/1ps
module hpi_device (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // host bus
    hpi_if.device            bus,
    // condition inputs from the engine
    input  wire logic        fetch_empty,
    input  wire logic        idle_cond,
    input  wire logic        stack_overflow,
    input  wire logic        stack_reload,
    input  wire logic        addr_out_of_range,
    input  wire logic        addr_write_inside,
    input  wire logic        clip_out,
    input  wire logic        clip_write_inside,
    input  wire logic        frame_loaded,
    input  wire logic        instr_fifo_full,
    input  wire logic        instr_fifo_below_half,
    input  wire logic        block_request_cond,
    input  wire logic        vertical_blank,
    input  wire logic        notify_pulse,
    // cascade
    input  wire logic        local_match,
    input  wire logic        instr_ready,
    input  wire logic        mem_cycle_start,
    input  wire logic        match_sync_in,
    input  wire logic        memory_timing_sync_in,
    output logic             match_sync_out,
    output logic             memory_timing_sync_out,
    output logic             instr_start,
    output logic             mem_cycle_go,
    output logic             match_all
);
    typedef struct packed {
        logic [15:0] rdata;
        logic        rvalid;
        logic        host_int;
        logic        fifo_pin;
        logic        block_pin;
        logic [8:0]  req;
        logic [8:0]  enable;
        logic        wide;
        logic        order;
        logic        second;
        logic [7:0]  held;
        logic [7:0]  index;
        logic        fifo_filled;
        logic        vblank_prev;
        logic        idle_hold;
        logic        sof_hold;
        logic        dmx_hold;
        logic        clip_hold;
        logic        mo;
        logic        to;
        logic        start;
        logic        go;
        logic        match;
    } hpi_dev_state_t;

    hpi_dev_state_t s_q, s_d;

    function automatic logic [15:0] read_reg(input hpi_dev_state_t s, input logic [7:0] idx);
        logic [15:0] v;
        v = 16'h0000;
        unique case (idx)
            hpi_pkg::REG_STATUS: begin
                v[hpi_pkg::STAT_SUMMARY]                         = |s.req;
                v[hpi_pkg::REQ_LSB +: hpi_pkg::NUM_REQ]          = s.req;
                v[hpi_pkg::STAT_IDLE]                            = idle_cond;
                v[hpi_pkg::STAT_FIFO_PIN]                        = s.fifo_pin;
                v[hpi_pkg::STAT_BLOCK_PIN]                       = s.block_pin;
            end
            hpi_pkg::REG_INT_ENABLE: v[hpi_pkg::REQ_LSB +: hpi_pkg::NUM_REQ] = s.enable;
            hpi_pkg::REG_BYTE_ORDER: v[0] = s.order;
            default:                 v = 16'h0000;
        endcase
        return v;
    endfunction

    logic [15:0] full_w;
    logic        wr_done;
    logic [8:0]  cond;
    logic [8:0]  rise;
    logic [8:0]  ack;
    logic [15:0] rv;

    always_comb begin
        s_d = s_q;
        s_d.rvalid = 1'b0;
        full_w = bus.wdata;
        wr_done = 1'b0;
        ack = 9'h000;
        rv = read_reg(s_q, s_q.index);
        // sticky condition states
        s_d.idle_hold = (s_q.idle_hold | fetch_empty) & idle_cond;
        s_d.sof_hold = (s_q.sof_hold | stack_overflow) & ~stack_reload;
        s_d.dmx_hold = (s_q.dmx_hold | addr_out_of_range) & ~addr_write_inside;
        s_d.clip_hold = (s_q.clip_hold | clip_out) & ~clip_write_inside;
        if (instr_fifo_full)
            s_d.fifo_filled = 1'b1;
        s_d.fifo_pin = ~s_q.fifo_filled | instr_fifo_below_half;
        s_d.block_pin = block_request_cond;
        s_d.vblank_prev = vertical_blank;
        cond = {notify_pulse, vertical_blank, s_q.block_pin, s_q.fifo_pin, frame_loaded,
                s_q.clip_hold | clip_out, s_q.dmx_hold | addr_out_of_range,
                s_q.sof_hold | stack_overflow, s_q.idle_hold | fetch_empty};
        rise = {notify_pulse,
                vertical_blank & ~s_q.vblank_prev,
                s_d.block_pin & ~s_q.block_pin,
                s_d.fifo_pin & ~s_q.fifo_pin,
                frame_loaded,
                clip_out,
                addr_out_of_range,
                stack_overflow,
                fetch_empty};
        if (bus.cs && bus.wr && bus.addr_sel) begin
            s_d.index = bus.wdata[7:0];
            s_d.second = 1'b0;
        end else if (bus.cs && (bus.wr || bus.rd)) begin
            if (!s_q.wide) begin
                // pairs by position only; a stray byte from another access corrupts the pair
                s_d.second = ~s_q.second;
                if (bus.wr && !s_q.second)
                    s_d.held = bus.wdata[7:0];
                if (bus.wr && s_q.second) begin
                    wr_done = 1'b1;
                    full_w = (s_q.order == hpi_pkg::HIGH_FIRST) ? {s_q.held, bus.wdata[7:0]}
                                                                : {bus.wdata[7:0], s_q.held};
                end
                if (bus.rd) begin
                    s_d.rdata = {8'h00, ((s_q.order == hpi_pkg::HIGH_FIRST) ^ s_q.second) ? rv[15:8] : rv[7:0]};
                    s_d.rvalid = 1'b1;
                end
            end else begin
                wr_done = bus.wr;
                if (bus.rd) begin
                    s_d.rdata = rv;
                    s_d.rvalid = 1'b1;
                end
            end
        end
        if (wr_done) begin
            unique case (s_q.index)
                hpi_pkg::REG_INT_ENABLE: s_d.enable = full_w[hpi_pkg::REQ_LSB +: hpi_pkg::NUM_REQ];
                hpi_pkg::REG_INT_ACK:    ack = full_w[hpi_pkg::REQ_LSB +: hpi_pkg::NUM_REQ];
                hpi_pkg::REG_BYTE_ORDER: s_d.order = full_w[0];
                default: ;
            endcase
        end
        // width switch takes effect on the first write to it, even in 16-bit mode
        if (bus.cs && bus.wr && !bus.addr_sel && s_q.index == hpi_pkg::REG_BUS_WIDTH)
            s_d.wide = 1'b0;
        s_d.req = (s_q.req & ~(ack & ~cond)) | rise;
        s_d.host_int = |(s_d.req & s_d.enable);
        // cascade: match wired-and across devices, start when all agree
        s_d.mo = local_match & instr_ready;
        s_d.match = match_sync_in & local_match;
        s_d.start = match_sync_in & s_q.mo;
        s_d.to = mem_cycle_start;
        s_d.go = memory_timing_sync_in;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_q <= '0;
            s_q.wide <= hpi_pkg::WIDE_BUS_RESET;
            s_q.order <= hpi_pkg::BYTE_ORDER_RESET;
            s_q.enable <= hpi_pkg::ENABLE_RESET[8:0];
            s_q.fifo_pin <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign bus.rdata = s_q.rdata;
    assign bus.rvalid = s_q.rvalid;
    assign bus.host_int = s_q.host_int;
    assign bus.instr_fifo_request_pin = s_q.fifo_pin;
    assign bus.block_transfer_request_pin = s_q.block_pin;
    assign match_sync_out = s_q.mo;
    assign memory_timing_sync_out = s_q.to;
    assign instr_start = s_q.start;
    assign mem_cycle_go = s_q.go;
    assign match_all = s_q.match;
endmodule

// ---- core/hpi_host.sv ----
/*
 * host end: turns register read/write requests into address write plus
 * one or two data transfers on the host bus, keeping byte pairs adjacent.
 * assumes user holds req until ack; group select is a sideband output.
 */
`timescale 1ns/1ps
module hpi_host (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // host bus
    hpi_if.host              bus,
    // user side
    input  wire logic        req,
    input  wire logic        req_write,
    input  wire logic [7:0]  req_index,
    input  wire logic [15:0] req_wdata,
    input  wire logic        req_group,
    output logic             ack,
    output logic [15:0]      rdata,
    output logic             group_select,
    output logic             int_seen,
    output logic             narrow_mode
);
    typedef enum logic [2:0] {H_IDLE, H_ADDR, H_FIRST, H_SECOND, H_WAIT} hpi_host_st_t;
    typedef struct packed {
        hpi_host_st_t st;
        logic         cs;
        logic         wr;
        logic         rd;
        logic         asel;
        logic [15:0]  wd;
        logic         ack;
        logic [15:0]  rdata;
        logic         group;
        logic         narrow;
        logic         order;
        logic         intr;
        logic [1:0]   got;
    } hpi_host_state_t;

    hpi_host_state_t s_q, s_d;

    always_comb begin
        s_d = s_q;
        s_d.ack = 1'b0;
        s_d.cs = 1'b0;
        s_d.wr = 1'b0;
        s_d.rd = 1'b0;
        s_d.asel = 1'b0;
        s_d.intr = bus.host_int;
        if (bus.rvalid) begin
            if (!s_q.narrow)
                s_d.rdata = bus.rdata;
            else if ((s_q.got == 2'h0) == (s_q.order == hpi_pkg::HIGH_FIRST))
                s_d.rdata[15:8] = bus.rdata[7:0];
            else
                s_d.rdata[7:0] = bus.rdata[7:0];
            s_d.got = s_q.got + 2'h1;
        end
        unique case (s_q.st)
            H_IDLE: if (req) begin
                // group select copies req_group for every request, set with the address write
                s_d.group = req_group;
                s_d.cs = 1'b1;
                s_d.wr = 1'b1;
                s_d.asel = 1'b1;
                s_d.wd = {8'h00, req_index};
                s_d.got = 2'h0;
                s_d.st = H_ADDR;
            end
            H_ADDR: begin
                s_d.cs = 1'b1;
                s_d.wr = req_write;
                s_d.rd = ~req_write;
                if (s_q.narrow)
                    s_d.wd = {8'h00, (s_q.order == hpi_pkg::HIGH_FIRST) ? req_wdata[15:8] : req_wdata[7:0]};
                else
                    s_d.wd = req_wdata;
                // wide read data lands a cycle after the strobe, so ack waits one more cycle
                s_d.st = s_q.narrow ? H_FIRST : H_SECOND;
            end
            H_FIRST: begin
                // second byte follows immediately so nothing can split the pair
                s_d.cs = 1'b1;
                s_d.wr = req_write;
                s_d.rd = ~req_write;
                s_d.wd = {8'h00, (s_q.order == hpi_pkg::HIGH_FIRST) ? req_wdata[7:0] : req_wdata[15:8]};
                s_d.st = H_SECOND;
            end
            H_SECOND: s_d.st = H_WAIT;
            H_WAIT: begin
                s_d.ack = 1'b1;
                s_d.st = H_IDLE;
                if (req_write && req_index == hpi_pkg::REG_BUS_WIDTH)
                    s_d.narrow = 1'b1;
                if (req_write && req_index == hpi_pkg::REG_BYTE_ORDER)
                    s_d.order = req_wdata[0];
            end
            default: s_d.st = H_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_q <= '0;
            s_q.st <= H_IDLE;
            s_q.order <= hpi_pkg::BYTE_ORDER_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign bus.cs = s_q.cs;
    assign bus.wr = s_q.wr;
    assign bus.rd = s_q.rd;
    assign bus.addr_sel = s_q.asel;
    assign bus.wdata = s_q.wd;
    assign ack = s_q.ack;
    assign rdata = s_q.rdata;
    assign group_select = s_q.group;
    assign int_seen = s_q.intr;
    assign narrow_mode = s_q.narrow;
endmodule

// ---- tb/hpi_monitor.sv ----
/*
 * checker on the host port bus wires between host end and device end.
 * assumes one sys_clk and instantiation beside the interface in the bench.
 */
`timescale 1ns/1ps
module hpi_monitor (
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        rst,
    // host strobes
    input wire logic        cs,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic        addr_sel,
    input wire logic [15:0] wdata,
    // device answers
    input wire logic [15:0] rdata,
    input wire logic        rvalid,
    input wire logic        host_int,
    input wire logic        instr_fifo_request_pin,
    input wire logic        block_transfer_request_pin
);
    logic [7:0]  idx_q;
    logic        narrow_q;
    logic        phase_q;
    logic [15:0] en_q;
    wire         ds = cs && (wr || rd) && !addr_sel;
    wire         rs = ds && rd;
    wire         aw = cs && wr && addr_sel;
    // shadow of index, width and enable; enable only tracked in 16-bit mode
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            idx_q    <= 8'h00;
            narrow_q <= 1'b0;
            phase_q  <= 1'b0;
            en_q     <= 16'h0000;
        end else begin
            if (aw) idx_q <= wdata[7:0];
            if (ds && wr && idx_q == hpi_pkg::REG_BUS_WIDTH) narrow_q <= 1'b1;
            if (aw) phase_q <= 1'b0;
            else if (ds && narrow_q) phase_q <= !phase_q;
            if (ds && wr && !narrow_q && idx_q == hpi_pkg::REG_INT_ENABLE) en_q <= wdata;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_read_answer: assert property (rs |=> rvalid)
        else $error("read strobe not answered");
    a_valid_cause: assert property (rvalid |-> $past(rs))
        else $error("answer without read strobe");
    a_narrow_upper: assert property (rvalid && narrow_q |-> rdata[15:8] == 8'h00)
        else $error("upper byte driven in narrow mode");
    a_status_or: assert property (rvalid && !narrow_q && idx_q == hpi_pkg::REG_STATUS |-> rdata[0] == |rdata[9:1])
        else $error("summary bit differs from requests");
    a_reset_pins: assert property (disable iff (1'b0) rst |=> instr_fifo_request_pin && !host_int)
        else $error("pins wrong after reset");
    a_pair_adjacent: assert property (ds && narrow_q && !phase_q |=> ds && wr == $past(wr))
        else $error("byte pair split");
    a_wide_single: assert property (ds && !narrow_q |=> !ds)
        else $error("second data transfer in wide mode");
    a_int_enable: assert property (!narrow_q && en_q == 16'h0000 && $past(en_q) == 16'h0000 |-> !host_int)
        else $error("interrupt with nothing enabled");
    c_narrow: cover property (ds && narrow_q);
    c_int: cover property (host_int);
    c_status: cover property (rvalid && idx_q == hpi_pkg::REG_STATUS);
endmodule

// ---- tb/hpi_bench.sv ----
/*
 * bench joining host end and device end; drives conditions and user requests.
 * assumes the host turns each request into the documented bus sequence.
 */
`timescale 1ns/1ps
module hpi_bench;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic [18:0] cv = 19'h00000;
    logic        req = 1'b0;
    logic        req_write = 1'b0;
    logic        req_group = 1'b0;
    logic [7:0]  req_index = 8'h00;
    logic [15:0] req_wdata = 16'h0000;
    logic [15:0] rdata, got, wb0, wb1, e;
    logic [4:0]  sync_o;
    int          n_xfer = 0;
    int          xs = 0;
    logic        ack, group_select, int_seen, narrow_mode;
    int          n_mismatch = 0;
    int          checked = 0;
    int          cyc = 0;
    // per request bit: inputs raised for one cycle, kept high, pulsed to end
    logic [18:0] set_m [9] = '{19'h00003, 19'h00004, 19'h00010, 19'h00040, 19'h00100,
                               19'h00400, 19'h00800, 19'h01000, 19'h02000};
    logic [18:0] hold_m [9] = '{19'h00002, 19'h00000, 19'h00000, 19'h00000, 19'h00000,
                                19'h00400, 19'h00800, 19'h01000, 19'h00000};
    logic [18:0] end_m [9] = '{19'h00000, 19'h00008, 19'h00020, 19'h00080, 19'h00000,
                               19'h00000, 19'h00000, 19'h00000, 19'h00000};
    always #50 sys_clk = ~sys_clk;
    hpi_if bus_if ();
    hpi_device hpi_device_i (.sys_clk(sys_clk), .rst(rst), .bus(bus_if.device),
        .fetch_empty(cv[0]), .idle_cond(cv[1]), .stack_overflow(cv[2]), .stack_reload(cv[3]),
        .addr_out_of_range(cv[4]), .addr_write_inside(cv[5]), .clip_out(cv[6]), .clip_write_inside(cv[7]),
        .frame_loaded(cv[8]), .instr_fifo_full(cv[9]), .instr_fifo_below_half(cv[10]),
        .block_request_cond(cv[11]), .vertical_blank(cv[12]), .notify_pulse(cv[13]), .local_match(cv[14]),
        .instr_ready(cv[15]), .mem_cycle_start(cv[16]), .match_sync_in(cv[17]), .memory_timing_sync_in(cv[18]),
        .match_sync_out(sync_o[4]), .memory_timing_sync_out(sync_o[3]), .instr_start(sync_o[2]),
        .mem_cycle_go(sync_o[1]), .match_all(sync_o[0]));
    hpi_host hpi_host_i (.sys_clk(sys_clk), .rst(rst), .bus(bus_if.host), .req(req), .req_write(req_write),
        .req_index(req_index), .req_wdata(req_wdata), .req_group(req_group), .ack(ack), .rdata(rdata),
        .group_select(group_select), .int_seen(int_seen), .narrow_mode(narrow_mode));
    hpi_monitor hpi_monitor_i (.sys_clk(sys_clk), .rst(rst), .cs(bus_if.cs), .wr(bus_if.wr), .rd(bus_if.rd),
        .addr_sel(bus_if.addr_sel), .wdata(bus_if.wdata), .rdata(bus_if.rdata), .rvalid(bus_if.rvalid),
        .host_int(bus_if.host_int), .instr_fifo_request_pin(bus_if.instr_fifo_request_pin),
        .block_transfer_request_pin(bus_if.block_transfer_request_pin));
    task automatic results;
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // last two data write bytes seen on the wire, oldest in wb1
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (bus_if.cs === 1'b1 && bus_if.wr === 1'b1 && bus_if.addr_sel === 1'b0) begin
            wb1 <= wb0;
            wb0 <= bus_if.wdata;
        end
        if (bus_if.cs === 1'b1 && (bus_if.wr === 1'b1 || bus_if.rd === 1'b1) && bus_if.addr_sel === 1'b0)
            n_xfer <= n_xfer + 1;
        if (cyc == 4000) begin
            n_mismatch++;
            results();
        end
    end
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] seen);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    // ack is a one-cycle pulse, so it is sampled at the falling edge
    task automatic access(input logic w, input logic [7:0] idx, input logic [15:0] d, input logic g);
        int k;
        @(negedge sys_clk);
        req = 1'b1;
        req_write = w;
        req_index = idx;
        req_wdata = d;
        req_group = g;
        for (k = 0; k < 40 && ack !== 1'b1; k++) @(negedge sys_clk);
        if (ack !== 1'b1) check("ack", 16'h0001, {15'h0000, ack});
        got = rdata;
        req = 1'b0;
        @(negedge sys_clk);
    endtask
    task automatic rd_chk(input string name, input logic [7:0] idx, input logic [15:0] exp);
        access(1'b0, idx, 16'h0000, 1'b0);
        check(name, exp, got);
    endtask
    initial begin
        tick(6);
        rst = 1'b0;
        rd_chk("enable_reset", hpi_pkg::REG_INT_ENABLE, hpi_pkg::ENABLE_RESET);
        check("narrow_reset", 16'h0000, {15'h0000, narrow_mode});
        cv = 19'h00200;
        tick(1);
        cv = 19'h00000;
        tick(3);
        access(1'b1, hpi_pkg::REG_INT_ACK, 16'h03FE, 1'b1);
        check("group", 16'h0001, {15'h0000, group_select});
        rd_chk("status_clear", hpi_pkg::REG_STATUS, 16'h0000);
        check("individual", 16'h0000, {15'h0000, group_select});
        for (int b = 1; b <= 9; b++) begin
            cv = set_m[b-1];
            tick(1);
            cv = hold_m[b-1];
            tick(3);
            e = (16'h0001 << b) | 16'h0001;
            e = e | {hold_m[b-1][11], hold_m[b-1][10], 3'b000, hold_m[b-1][1], 10'h000};
            rd_chk("status_set", hpi_pkg::REG_STATUS, e);
            if ((hold_m[b-1] | end_m[b-1]) != 19'h00000) begin
                access(1'b1, hpi_pkg::REG_INT_ACK, 16'h0001 << b, 1'b1);
                rd_chk("status_held", hpi_pkg::REG_STATUS, e);
            end
            cv = end_m[b-1];
            tick(1);
            cv = 19'h00000;
            tick(3);
            access(1'b1, hpi_pkg::REG_INT_ACK, 16'h0001 << b, 1'b1);
            rd_chk("status_cleared", hpi_pkg::REG_STATUS, 16'h0000);
        end
        // a condition still present at the acknowledge keeps its request
        cv = 19'h00100;
        access(1'b1, hpi_pkg::REG_INT_ACK, 16'h0020, 1'b1);
        cv = 19'h00000;
        rd_chk("set_wins", hpi_pkg::REG_STATUS, 16'h0021);
        access(1'b1, hpi_pkg::REG_INT_ACK, 16'h0020, 1'b1);
        rd_chk("set_cleared", hpi_pkg::REG_STATUS, 16'h0000);
        access(1'b1, hpi_pkg::REG_INT_ENABLE, 16'h0200, 1'b0);
        cv = 19'h02000;
        tick(1);
        cv = 19'h00000;
        tick(3);
        check("int_on", 16'h0001, {15'h0000, int_seen});
        access(1'b1, hpi_pkg::REG_INT_ACK, 16'h0200, 1'b1);
        tick(2);
        check("int_off", 16'h0000, {15'h0000, int_seen});
        xs = n_xfer;
        access(1'b1, hpi_pkg::REG_INT_ENABLE, 16'h0000, 1'b0);
        check("wide_count", 16'h0001, 16'(n_xfer - xs));
        cv = 19'h7C000;
        tick(4);
        check("sync_on", 16'h001F, {11'h000, sync_o});
        cv = 19'h00000;
        tick(4);
        check("sync_off", 16'h0000, {11'h000, sync_o});
        // narrow mode sticks until reset, so it comes last
        access(1'b1, hpi_pkg::REG_BUS_WIDTH, 16'h0001, 1'b1);
        check("narrow_set", 16'h0001, {15'h0000, narrow_mode});
        xs = n_xfer;
        access(1'b1, hpi_pkg::REG_INT_ENABLE, 16'h0204, 1'b0);
        check("narrow_count", 16'h0002, 16'(n_xfer - xs));
        check("wire_high_first", 16'h0204, {wb1[7:0], wb0[7:0]});
        rd_chk("enable_high_first", hpi_pkg::REG_INT_ENABLE, 16'h0204);
        access(1'b1, hpi_pkg::REG_BYTE_ORDER, 16'h0001, 1'b1);
        access(1'b1, hpi_pkg::REG_INT_ENABLE, 16'h0012, 1'b0);
        check("wire_low_first", 16'h1200, {wb1[7:0], wb0[7:0]});
        rd_chk("enable_low_first", hpi_pkg::REG_INT_ENABLE, 16'h0012);
        results();
    end
endmodule
